// *** cke_state_defs.svh ***
`ifndef CKE_STATE_DEFS_SVH
`define CKE_STATE_DEFS_SVH

// Burst length code that cannot be interrupted
`define BL_FOUR 4'h4
// Beats per burst counter value helpers
`define BEAT_ONE 4'h1
`define BEAT_ZERO 4'h0
// Self-refresh exit to read delay in clocks
`define XSRD_CLOCKS 8'hC8
// Minimum clock enable hold in clocks
`define CKE_HOLD_CLOCKS 2'h3
`define DATA_W 8

`endif

// *** cke_state_pkg.sv ***
package cke_state_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ACTIVE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b011,
    ST_PWR_DOWN = 3'b100,
    ST_SELF_REFRESH = 3'b101
  } dev_state_t;

  typedef enum logic [2:0] {
    CMD_NOP = 3'b000,
    CMD_ACT = 3'b001,
    CMD_PRE = 3'b010,
    CMD_READ = 3'b011,
    CMD_WRITE = 3'b100,
    CMD_REF = 3'b101,
    CMD_MRS = 3'b110
  } cmd_t;
endpackage

// *** cke_state_props.sv ***
`timescale 1ns/1ps
module cke_state_props (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic i_wr_beat,
  input wire logic i_dm,
  input wire logic [2:0] o_state,
  input wire logic o_precharge_pd,
  input wire logic o_active_pd,
  input wire logic o_read_allowed,
  input wire logic o_illegal,
  input wire logic o_wr_en
);
  logic p_q;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) p_q <= 1'b1;
    else p_q <= i_cke;
  end
  wire nop = i_cs_n | (i_ras_n & i_cas_n & i_we_n);
  wire act = !i_cs_n & !i_ras_n & i_cas_n & i_we_n;
  wire rd = !i_cs_n & i_ras_n & !i_cas_n & i_we_n;
  wire rf = !i_cs_n & !i_ras_n & !i_cas_n & i_we_n;
  wire hh = p_q & i_cke;
  wire hl = p_q & !i_cke;
  wire idle = o_state == cke_state_pkg::ST_IDLE;
  wire actv = o_state == cke_state_pkg::ST_ACTIVE;
  wire pd = o_state == cke_state_pkg::ST_PWR_DOWN;
  wire sr = o_state == cke_state_pkg::ST_SELF_REFRESH;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  a_pd_hold: assert property (pd && !p_q && !i_cke |=> pd)
    else $error("power-down not held");
  a_pd_exit: assert property (pd && o_precharge_pd && !p_q && i_cke && nop
    |=> idle) else $error("power-down exit wrong");
  a_pre_pd: assert property (idle && hl && nop |=> pd && o_precharge_pd
    && !o_active_pd) else $error("precharge power-down wrong");
  a_act_pd: assert property (actv && hl && nop |=> pd && o_active_pd)
    else $error("active power-down wrong");
  a_sr_entry: assert property (idle && hl && rf |=> sr)
    else $error("self-refresh entry missed");
  a_row_act: assert property (idle && hh && act |=> actv)
    else $error("activate ignored");
  a_rd_begin: assert property (actv && hh && rd |=>
    o_state == cke_state_pkg::ST_READ) else $error("read not begun");
  a_bad_read: assert property (idle && hh && rd |=> o_illegal && idle)
    else $error("illegal read not flagged");
  a_mask_beat: assert property (1'b1 |=> o_wr_en == $past(i_wr_beat && !i_dm))
    else $error("mask misapplied");
  a_sr_no_read: assert property (sr |-> !o_read_allowed)
    else $error("read allowed in self-refresh");
endmodule // cke_state_props
bind ddr2_cke_command_state_logic cke_state_props u_cke_state_props (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cke(i_cke), .i_cs_n(i_cs_n),
  .i_ras_n(i_ras_n), .i_cas_n(i_cas_n), .i_we_n(i_we_n), .i_dm(i_dm),
  .i_wr_beat(i_wr_beat), .o_state(o_state), .o_precharge_pd(o_precharge_pd),
  .o_active_pd(o_active_pd), .o_read_allowed(o_read_allowed),
  .o_illegal(o_illegal), .o_wr_en(o_wr_en));

// *** ddr2_cke_command_state_logic.sv ***
// Function
// - Action per edge uses prior state, previous and current CKE, and command.
// - Unlisted state/CKE/command combinations are illegal; controller avoids them.
// - Power-down held while CKE low twice; exits on CKE rise with NOP/deselect.
// - No refresh in power-down; controller bounds power-down duration.
// - Termination input never affects CKE transitions; unavailable in self-refresh.
// - Data beat written when mask low, blocked when mask high, same beat.
// - Idle: NOP stays or powers down, ACT activates, PRE, REF, MRS act.
// - Active: NOP stays or powers down, read/write begin bursts, precharge; others illegal.
// - Read burst: NOP continues, read interrupts; write burst: write interrupts.
// - Power-down is precharge type from idle, active type with open rows.
// - Length-four bursts cannot be interrupted; interrupts for any other length.
// - Deselect is chip-select high; NOP is chip-select low, strobes high.
`timescale 1ns/1ps
`include "cke_state_defs.svh"

module ddr2_cke_command_state_logic (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Command pins
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic i_odt,
  // Burst configuration
  input wire logic [3:0] i_burst_len,
  // Write data path
  input wire logic i_wr_beat,
  input wire logic i_dm,
  input wire logic [`DATA_W-1:0] i_wr_data,
  // State and status
  output logic [2:0] o_state,
  output logic o_precharge_pd,
  output logic o_active_pd,
  output logic o_odt_active,
  output logic o_read_allowed,
  output logic o_illegal,
  output logic o_cke_hold_err,
  // Masked write output
  output logic o_wr_en,
  output logic [`DATA_W-1:0] o_wr_data
);

  cke_state_pkg::dev_state_t state_q, state_d;
  logic cke_prev_q;
  logic [3:0] beats_q, beats_d;
  logic [7:0] xsrd_q;
  logic [1:0] hold_q;
  logic pre_pd_q, act_pd_q, illegal_q, hold_err_q;
  logic wr_en_q;
  logic [`DATA_W-1:0] wr_data_q;
  logic bad_d;
  logic odt_q, rd_ok_q;

  ////////////////////////////////////////////////////////////////////////
  // Command decode
  wire desel = i_cs_n;
  wire nop = desel | (~i_ras_n & 1'b0) |
             (~i_cs_n & i_ras_n & i_cas_n & i_we_n);
  wire lo = ~i_cs_n;
  wire c_act = lo & ~i_ras_n & i_cas_n & i_we_n;
  wire c_pre = lo & ~i_ras_n & i_cas_n & ~i_we_n;
  wire c_read = lo & i_ras_n & ~i_cas_n & i_we_n;
  wire c_write = lo & i_ras_n & ~i_cas_n & ~i_we_n;
  wire c_ref = lo & ~i_ras_n & ~i_cas_n & i_we_n;
  wire c_mrs = lo & ~i_ras_n & ~i_cas_n & ~i_we_n;
  // Termination input deliberately absent from the transition logic
  wire cke_hh = cke_prev_q & i_cke;
  wire cke_hl = cke_prev_q & ~i_cke;
  wire cke_lh = ~cke_prev_q & i_cke;
  wire can_intr = (i_burst_len != `BL_FOUR);
  wire burst_last = (beats_q == `BEAT_ONE);
  wire in_sr = (state_q == cke_state_pkg::ST_SELF_REFRESH);
  // Next-cycle view so the read permit can leave a flip-flop
  wire sr_nx = bad_d ? in_sr :
               (state_d == cke_state_pkg::ST_SELF_REFRESH);
  wire [7:0] xsrd_nx = in_sr ? `XSRD_CLOCKS :
                       ((xsrd_q != 8'h00) ? xsrd_q - 8'h01 : xsrd_q);

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    state_d = state_q;
    beats_d = beats_q;
    bad_d = 1'b0;
    case (state_q)
      // No refresh is done here; the controller bounds the stay
      cke_state_pkg::ST_PWR_DOWN, cke_state_pkg::ST_SELF_REFRESH: begin
        if (cke_lh & nop) begin
          state_d = (in_sr | pre_pd_q) ? cke_state_pkg::ST_IDLE :
                    cke_state_pkg::ST_ACTIVE;
        end else if (cke_lh | cke_prev_q) begin
          bad_d = 1'b1;
        end
      end
      cke_state_pkg::ST_IDLE: begin
        if (cke_hl & nop) begin
          state_d = cke_state_pkg::ST_PWR_DOWN;
        end else if (cke_hl & c_ref) begin
          state_d = cke_state_pkg::ST_SELF_REFRESH;
        end else if (cke_hh & c_act) begin
          state_d = cke_state_pkg::ST_ACTIVE;
        end else if (cke_hh & (nop | c_pre | c_ref | c_mrs)) begin
          state_d = cke_state_pkg::ST_IDLE;
        end else begin
          bad_d = 1'b1;
        end
      end
      cke_state_pkg::ST_ACTIVE: begin
        if (cke_hl & nop) begin
          state_d = cke_state_pkg::ST_PWR_DOWN;
        end else if (cke_hh & nop) begin
          state_d = cke_state_pkg::ST_ACTIVE;
        end else if (cke_hh & c_read) begin
          state_d = cke_state_pkg::ST_READ;
          beats_d = i_burst_len;
        end else if (cke_hh & c_write) begin
          state_d = cke_state_pkg::ST_WRITE;
          beats_d = i_burst_len;
        end else if (cke_hh & c_pre) begin
          state_d = cke_state_pkg::ST_IDLE;
        end else begin
          bad_d = 1'b1;
        end
      end
      cke_state_pkg::ST_READ, cke_state_pkg::ST_WRITE: begin
        if (cke_hh & nop) begin
          beats_d = beats_q - `BEAT_ONE;
          if (burst_last) begin
            state_d = cke_state_pkg::ST_ACTIVE;
          end
        end else if (cke_hh & can_intr &
                     ((state_q == cke_state_pkg::ST_READ) ? c_read :
                      c_write)) begin
          beats_d = i_burst_len;
        end else begin
          bad_d = 1'b1;
        end
      end
      default: begin
        state_d = cke_state_pkg::ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_q <= cke_state_pkg::ST_IDLE;
      beats_q <= `BEAT_ZERO;
      cke_prev_q <= 1'b1;
      illegal_q <= 1'b0;
    end else begin
      state_q <= bad_d ? state_q : state_d;
      beats_q <= bad_d ? beats_q : beats_d;
      cke_prev_q <= i_cke;
      illegal_q <= bad_d;
    end
  end

  // Power-down flavour captured at entry
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pre_pd_q <= 1'b0;
      act_pd_q <= 1'b0;
    end else if (!bad_d && state_d == cke_state_pkg::ST_PWR_DOWN &&
                 state_q != cke_state_pkg::ST_PWR_DOWN) begin
      pre_pd_q <= (state_q == cke_state_pkg::ST_IDLE);
      act_pd_q <= (state_q == cke_state_pkg::ST_ACTIVE);
    end else if (state_q != cke_state_pkg::ST_PWR_DOWN) begin
      pre_pd_q <= 1'b0;
      act_pd_q <= 1'b0;
    end
  end

  // Exit-to-read counter after self-refresh
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      xsrd_q <= 8'h00;
      rd_ok_q <= 1'b1;
    end else begin
      xsrd_q <= xsrd_nx;
      rd_ok_q <= (xsrd_nx == 8'h00) & ~sr_nx;
    end
  end

  // Clock-enable hold checker
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      hold_q <= `CKE_HOLD_CLOCKS;
      hold_err_q <= 1'b0;
    end else if (i_cke != cke_prev_q) begin
      hold_err_q <= (hold_q != `CKE_HOLD_CLOCKS);
      hold_q <= 2'h1;
    end else begin
      hold_err_q <= 1'b0;
      if (hold_q != `CKE_HOLD_CLOCKS) begin
        hold_q <= hold_q + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write data masking
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wr_en_q <= 1'b0;
      wr_data_q <= '0;
    end else begin
      wr_en_q <= i_wr_beat & ~i_dm;
      wr_data_q <= i_wr_data;
    end
  end

  assign o_state = state_q;
  assign o_precharge_pd = pre_pd_q;
  assign o_active_pd = act_pd_q;
  assign o_illegal = illegal_q;
  assign o_cke_hold_err = hold_err_q;
  assign o_read_allowed = rd_ok_q;
  assign o_odt_active = odt_q;
  assign o_wr_en = wr_en_q;
  assign o_wr_data = wr_data_q;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      odt_q <= 1'b0;
    end else begin
      odt_q <= i_odt & (state_d != cke_state_pkg::ST_SELF_REFRESH);
    end
  end

endmodule // ddr2_cke_command_state_logic

// *** ddr2_cke_command_state_logic_tb_top.sv ***
`timescale 1ns/1ps
`include "cke_state_defs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
  $display("BAD %0t compare", $time); end end
module ddr2_cke_command_state_logic_tb_top;
  logic i_clk_sys = 0, i_rst = 1, cke = 1, deselect_cmd = 0, odt = 0, beat = 0, dm = 0;
  logic [3:0] bl = 4'h8;
  logic [`DATA_W-1:0] wd = 8'h00, wq;
  cke_state_pkg::cmd_t cmd = cke_state_pkg::CMD_NOP;
  logic cs_n, ras_n, cas_n, we_n, ppd, apd, odta, rdok, ill, herr, wen;
  logic [2:0] st;
  int mismatches = 0, checked = 0, cycles = 0;
  initial begin
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  ddr2_ctrl_model u_ddr2_ctrl_model (.i_cmd(cmd), .i_dsl(deselect_cmd), .o_cs_n(cs_n),
    .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n));
  ddr2_cke_command_state_logic u_ddr2_cke_command_state_logic (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cke(cke), .i_cs_n(cs_n),
    .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_odt(odt),
    .i_burst_len(bl), .i_wr_beat(beat), .i_dm(dm), .i_wr_data(wd),
    .o_state(st), .o_precharge_pd(ppd), .o_active_pd(apd),
    .o_odt_active(odta), .o_read_allowed(rdok), .o_illegal(ill),
    .o_cke_hold_err(herr), .o_wr_en(wen), .o_wr_data(wq));
  task automatic end_of_test();
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      end_of_test();
    end
  end
  // One command edge, then let its updates land; odt left as it is
  task automatic cyc(input cke_state_pkg::cmd_t c, input logic k, d);
    @(negedge i_clk_sys);
    cmd = c;
    cke = k;
    deselect_cmd = d;
    @(posedge i_clk_sys);
    #1;
  endtask
  task automatic nops(input int n, input logic k);
    repeat (n) cyc(cke_state_pkg::CMD_NOP, k, 1'b0);
  endtask
  task automatic t_pd();
    cyc(cke_state_pkg::CMD_NOP, 1'b0, 1'b1);
    `CHK(st, cke_state_pkg::ST_PWR_DOWN);
    `CHK({ppd, apd}, 2'h2);
    nops(2, 1'b0);
    `CHK(st, cke_state_pkg::ST_PWR_DOWN);
    cyc(cke_state_pkg::CMD_NOP, 1'b1, 1'b1);
    `CHK(st, cke_state_pkg::ST_IDLE);
    nops(2, 1'b1);
  endtask
  task automatic t_burst();
    cyc(cke_state_pkg::CMD_ACT, 1'b1, 1'b0);
    `CHK(st, cke_state_pkg::ST_ACTIVE);
    cyc(cke_state_pkg::CMD_READ, 1'b1, 1'b0);
    `CHK(st, cke_state_pkg::ST_READ);
    nops(8, 1'b1);
    `CHK(st, cke_state_pkg::ST_ACTIVE);
    cyc(cke_state_pkg::CMD_WRITE, 1'b1, 1'b0);
    nops(3, 1'b1);
    cyc(cke_state_pkg::CMD_WRITE, 1'b1, 1'b0);
    nops(7, 1'b1);
    `CHK(st, cke_state_pkg::ST_WRITE);
    nops(1, 1'b1);
    `CHK(st, cke_state_pkg::ST_ACTIVE);
    nops(1, 1'b0);
    `CHK({ppd, apd}, 2'h1);
    nops(2, 1'b0);
    cyc(cke_state_pkg::CMD_NOP, 1'b1, 1'b1);
    `CHK(st, cke_state_pkg::ST_ACTIVE);
    nops(2, 1'b1);
    cyc(cke_state_pkg::CMD_PRE, 1'b1, 1'b0);
    `CHK(st, cke_state_pkg::ST_IDLE);
  endtask
  task automatic t_sr();
    odt = 1'b1;
    nops(2, 1'b1);
    cyc(cke_state_pkg::CMD_REF, 1'b0, 1'b0);
    nops(2, 1'b0);
    `CHK(st, cke_state_pkg::ST_SELF_REFRESH);
    `CHK({rdok, odta}, 2'h0);
    cyc(cke_state_pkg::CMD_NOP, 1'b1, 1'b1);
    `CHK(st, cke_state_pkg::ST_IDLE);
    `CHK(odta, 1'b1);
    nops(190, 1'b1);
    `CHK(rdok, 1'b0);
    nops(15, 1'b1);
    `CHK(rdok, 1'b1);
  endtask
  task automatic t_ill();
    cyc(cke_state_pkg::CMD_READ, 1'b1, 1'b0);
    `CHK({ill, st}, {1'b1, cke_state_pkg::ST_IDLE});
    nops(1, 1'b1);
    `CHK(ill, 1'b0);
    cyc(cke_state_pkg::CMD_NOP, 1'b0, 1'b1);
    cyc(cke_state_pkg::CMD_NOP, 1'b1, 1'b1);
    `CHK(herr, 1'b1);
    nops(3, 1'b1);
    `CHK(herr, 1'b0);
  endtask
  task automatic t_mask();
    for (int i = 0; i < 2; i++) begin
      @(negedge i_clk_sys);
      beat = 1'b1;
      dm = i[0];
      wd = 8'hA5 ^ i[7:0];
      @(posedge i_clk_sys);
      #1;
      `CHK(wen, !dm);
      if (!dm) `CHK(wq, wd);
    end
    @(negedge i_clk_sys);
    beat = 1'b0;
  endtask
  initial begin
    repeat (6) @(negedge i_clk_sys);
    i_rst = 1'b0;
    nops(3, 1'b1);
    t_pd();
    t_burst();
    t_sr();
    t_ill();
    t_mask();
    end_of_test();
  end
endmodule // ddr2_cke_command_state_logic_tb_top

// *** ddr2_ctrl_model.sv ***
`timescale 1ns/1ps
module ddr2_ctrl_model (
  // Command request
  input cke_state_pkg::cmd_t i_cmd,
  input wire logic i_dsl,
  // Command pins
  output logic o_cs_n,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n
);
  logic [3:0] pins;
  always_comb begin
    case (i_cmd)
      cke_state_pkg::CMD_ACT: pins = 4'h3;
      cke_state_pkg::CMD_PRE: pins = 4'h2;
      cke_state_pkg::CMD_READ: pins = 4'h5;
      cke_state_pkg::CMD_WRITE: pins = 4'h4;
      cke_state_pkg::CMD_REF: pins = 4'h1;
      cke_state_pkg::CMD_MRS: pins = 4'h0;
      default: pins = 4'h7;
    endcase
  end
  // Deselected strobes carry the command pattern inverted, not a NOP pattern
  assign o_cs_n = pins[3] | i_dsl;
  assign o_ras_n = pins[2] ^ i_dsl;
  assign o_cas_n = pins[1] ^ i_dsl;
  assign o_we_n = pins[0] ^ i_dsl;
endmodule // ddr2_ctrl_model
